// >>> rtl/hitless_regs.svh
// Offsets, field positions, reset values and timing counts of the hitless control block
`ifndef HITLESS_REGS_SVH
`define HITLESS_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_IRQ_STATUS  12'h004
`define OFS_IRQ_MASK    12'h008
`define OFS_STATE       12'h00C

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_HS_EN      0
`define EV_LOCK_LOSS    0
`define EV_RECOVERED    1
`define EV_RESELECT     2
`define EV_W            3
`define ST_FSM_LO       0
`define ST_FSM_HI       2
`define ST_REF_ACK      3
`define ST_ARMED        4
`define ST_LOCK_LOSS    5
`define ST_NARROW       6
`define ST_AUTO_ARMED   7

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CTRL_RST        1'h1
`define MASK_RST        3'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS   25
`define TRANSIENT_NS    4
`define LOCK_WIN_NS     2
`define LOCK_CYCLES     4'h8
`define RESUME_NS       175
`define RESUME_CYC      ((`RESUME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> rtl/hitless_pkg.sv
// Types shared by the hitless control block
`default_nettype none
package hitless_pkg;
  // Recovery sequence states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ARMED   = 3'b001,
    ST_FREEZE  = 3'b010,
    ST_REALIGN = 3'b011,
    ST_RELOCK  = 3'b100,
    ST_RESUME  = 3'b101
  } hs_state_t;
endpackage
`default_nettype wire

// >>> rtl/hitless_switch_bandwidth_ctrl.sv
// Loop bandwidth, reference reselection and hitless recovery control
`timescale 1ns/1ps
`default_nettype none
`include "hitless_regs.svh"

module hitless_switch_bandwidth_ctrl #(
  parameter bit HS_OPTION  = 1'b1, // Hitless recovery built in
  parameter bit PBO_OPTION = 1'b1, // Feedback realign built in
  parameter int EDGE_W     = 4     // Width of feedback edge select
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Board mode pins
  input  wire logic              auto_mode,
  input  wire logic              ref_select,
  input  wire logic              narrow_loop_select,
  input  wire logic              init_enable,
  // Phase detector side
  input  wire logic              pd_valid,
  input  wire logic [3:0]        phase_err_ns,
  input  wire logic [EDGE_W-1:0] nearest_edge,
  // Loop control outputs
  output logic                   lock_loss_flag,
  output logic                   ref_ack,
  output logic                   pd_enable,
  output logic                   loop_res_high,
  output logic [EDGE_W-1:0]      fb_edge_sel,
  output logic                   fb_edge_load,
  output logic                   hitless_recovery,
  // Interrupt
  output logic                   irq
);

  // ---------------------------------------------------------------
  // Lock detection
  // ---------------------------------------------------------------
  logic       transient;   // Large phase step this cycle
  logic       in_window;   // Valid cycle inside lock window
  logic [3:0] good_cnt;    // Consecutive in-window cycles
  logic [3:0] clean_cnt;   // Consecutive cycles with no loss
  logic       lol_q;       // Flag one cycle ago
  logic       lol_rise;    // Rising edge of the flag

  assign transient = pd_valid && (phase_err_ns >= 4'(`TRANSIENT_NS));
  assign in_window = pd_valid && (phase_err_ns <= 4'(`LOCK_WIN_NS));
  assign lol_rise  = lock_loss_flag && !lol_q;

  // Window counter, cleared on any valid cycle outside the window
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      good_cnt <= 4'h0;
    end else if (transient || (pd_valid && !in_window)) begin
      good_cnt <= 4'h0;
    end else if (in_window && good_cnt != `LOCK_CYCLES) begin
      good_cnt <= good_cnt + 4'h1;
    end
  end

  // Clean-cycle counter for start-up override
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clean_cnt <= 4'h0;
    end else if (transient) begin
      clean_cnt <= 4'h0;
    end else if (pd_valid && clean_cnt != `LOCK_CYCLES) begin
      clean_cnt <= clean_cnt + 4'h1;
    end
  end

  // Lock-loss flag: set by transient, cleared on eight good cycles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_loss_flag <= 1'b1;
      lol_q          <= 1'b1;
    end else begin
      lol_q <= lock_loss_flag;
      if (transient) begin
        lock_loss_flag <= 1'b1;
      end else if (good_cnt == `LOCK_CYCLES) begin
        lock_loss_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic            hs_sw_en;  // Software enable of recovery
  logic [`EV_W-1:0] ev_stat;  // Sticky events
  logic [`EV_W-1:0] ev_mask;  // Interrupt mask
  logic [`EV_W-1:0] ev_set;   // Event pulses this cycle
  logic            wr_ok;     // Write completes this cycle

  assign wr_ok = psel && penable && pwrite;

  // ---------------------------------------------------------------
  // Recovery sequence
  // ---------------------------------------------------------------
  hitless_pkg::hs_state_t state;     // Sequence state
  logic [3:0]             tmr;       // Resume timer count
  logic                   hs_on;     // Recovery usable

  assign hs_on = HS_OPTION && hs_sw_en;

  // Sequence state machine
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= hitless_pkg::ST_IDLE;
    end else if (!hs_on) begin
      state <= hitless_pkg::ST_IDLE;
    end else begin
      unique case (state)
        hitless_pkg::ST_IDLE: begin
          // Arm once lock is seen
          if (!lock_loss_flag) begin
            state <= hitless_pkg::ST_ARMED;
          end
        end
        hitless_pkg::ST_ARMED: begin
          // Any mode, rising flag triggers
          if (lol_rise) begin
            state <= hitless_pkg::ST_FREEZE;
          end
        end
        hitless_pkg::ST_FREEZE: begin
          // Detector off, loop narrowed
          state <= PBO_OPTION ? hitless_pkg::ST_REALIGN
                              : hitless_pkg::ST_RELOCK;
        end
        hitless_pkg::ST_REALIGN: begin
          state <= hitless_pkg::ST_RELOCK;
        end
        hitless_pkg::ST_RELOCK: begin
          // Wait for eight in-window cycles
          if (good_cnt == `LOCK_CYCLES) begin
            state <= hitless_pkg::ST_RESUME;
          end
        end
        hitless_pkg::ST_RESUME: begin
          // Timer expiry re-arms
          if (transient) begin
            state <= hitless_pkg::ST_RELOCK;
          end else if (tmr == 4'(`RESUME_CYC - 1)) begin
            state <= hitless_pkg::ST_ARMED;
          end
        end
        default: begin
          state <= hitless_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Resume timer, counts clock cycles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr <= 4'h0;
    end else if (state == hitless_pkg::ST_RESUME) begin
      tmr <= tmr + 4'h1;
    end else begin
      tmr <= 4'h0;
    end
  end

  // Feedback edge realign in whole oscillator cycles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fb_edge_sel  <= '0;
      fb_edge_load <= 1'b0;
    end else begin
      fb_edge_load <= (state == hitless_pkg::ST_REALIGN);
      if (state == hitless_pkg::ST_REALIGN) begin
        fb_edge_sel <= nearest_edge;
      end
    end
  end

  // Detector off only while frozen or realigning
  assign pd_enable = !(state == hitless_pkg::ST_FREEZE ||
                       state == hitless_pkg::ST_REALIGN);
  assign hitless_recovery = (state == hitless_pkg::ST_FREEZE) ||
                            (state == hitless_pkg::ST_REALIGN) ||
                            (state == hitless_pkg::ST_RELOCK) ||
                            (state == hitless_pkg::ST_RESUME);

  // ---------------------------------------------------------------
  // Bandwidth selection
  // ---------------------------------------------------------------
  logic init_done; // Start-up override finished

  // Start-up override latch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_done <= 1'b0;
    end else if (clean_cnt == `LOCK_CYCLES) begin
      init_done <= 1'b1;
    end
  end

  // High resistance: recovery, or pin narrow with init_enable high after start-up
  assign loop_res_high = hitless_recovery ||
                         (init_enable && narrow_loop_select &&
                          init_done);

  // ---------------------------------------------------------------
  // Reference reselection
  // ---------------------------------------------------------------
  logic auto_armed;  // One reselection pending
  logic auto_spent;  // Used; needs manual mode
  logic switched;    // Toggle against pin choice

  // Auto arming and single reselection; keeps manual selection
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      auto_armed <= 1'b0;
      auto_spent <= 1'b0;
      switched   <= 1'b0;
    end else if (!auto_mode) begin
      // Manual mode re-permits arming, pin rules
      auto_armed <= 1'b0;
      auto_spent <= 1'b0;
      switched   <= 1'b0;
    end else if (auto_armed && lol_rise) begin
      // Single reselection, recovery runs alongside
      auto_armed <= 1'b0;
      auto_spent <= 1'b1;
      switched   <= !switched;
    end else if (!auto_spent && !lock_loss_flag) begin
      auto_armed <= 1'b1;
    end
  end

  // Acknowledge shows the pair on the detector
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_ack <= 1'b0;
    end else begin
      // Manual mode shows the pin on the next clock, even in the cycle switched clears
      ref_ack <= ref_select ^ (auto_mode && switched);
    end
  end

  // ---------------------------------------------------------------
  // APB slave and interrupts
  // ---------------------------------------------------------------
  logic hit; // Mapped address

  assign pready  = 1'b1;
  assign hit     = (paddr == `OFS_CTRL) || (paddr == `OFS_IRQ_STATUS) ||
                   (paddr == `OFS_IRQ_MASK) || (paddr == `OFS_STATE);
  assign pslverr = psel && penable && !hit;
  assign ev_set  = {auto_mode && auto_armed && lol_rise,
                    (state == hitless_pkg::ST_RESUME) && !transient &&
                    (tmr == 4'(`RESUME_CYC - 1)),
                    lol_rise};

  // Control and mask writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_sw_en <= `CTRL_RST;
      ev_mask  <= `MASK_RST;
    end else if (wr_ok) begin
      if (paddr == `OFS_CTRL) begin
        hs_sw_en <= pwdata[`CTRL_HS_EN];
      end
      if (paddr == `OFS_IRQ_MASK) begin
        ev_mask <= pwdata[`EV_W-1:0];
      end
    end
  end

  // Sticky events, set wins over write-one clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_stat <= '0;
    end else begin
      ev_stat <= (ev_stat & ~((wr_ok && paddr == `OFS_IRQ_STATUS) ?
                              pwdata[`EV_W-1:0] : {`EV_W{1'b0}})) | ev_set;
    end
  end

  assign irq = |(ev_stat & ev_mask);

  // Read data, zero for unmapped
  always_comb begin
    prdata = 32'h0;
    unique case (paddr)
      `OFS_CTRL:       prdata[`CTRL_HS_EN] = hs_sw_en;
      `OFS_IRQ_STATUS: prdata[`EV_W-1:0]  = ev_stat;
      `OFS_IRQ_MASK:   prdata[`EV_W-1:0]  = ev_mask;
      `OFS_STATE: begin
        prdata[`ST_FSM_HI:`ST_FSM_LO] = state;
        prdata[`ST_REF_ACK]   = ref_ack;
        prdata[`ST_ARMED]     = (state == hitless_pkg::ST_ARMED);
        prdata[`ST_LOCK_LOSS] = lock_loss_flag;
        prdata[`ST_NARROW]    = loop_res_high;
        prdata[`ST_AUTO_ARMED] = auto_armed;
      end
      default: prdata = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_transient_sets_flag: assert property (
    transient |=> lock_loss_flag)
    else $error("transient did not raise lock loss");
  a_no_trigger_unarmed: assert property (
    state == hitless_pkg::ST_IDLE && lock_loss_flag |=> state == hitless_pkg::ST_IDLE)
    else $error("recovery triggered before arming");
  a_trigger_freezes: assert property (
    state == hitless_pkg::ST_ARMED && lol_rise && hs_on |=>
    !pd_enable && loop_res_high)
    else $error("trigger did not freeze and narrow");
  a_manual_keeps_ref: assert property (
    !auto_mode |=> ref_ack == $past(ref_select))
    else $error("manual mode changed selection");
  a_pd_back_on: assert property (
    state == hitless_pkg::ST_FREEZE |-> ##[1:2] pd_enable)
    else $error("detector not re-enabled");
  a_resume_timer: assert property (
    state == hitless_pkg::ST_RELOCK ##1 state == hitless_pkg::ST_RESUME
    ##0 !transient [*7] |=> state == hitless_pkg::ST_ARMED)
    else $error("resume timer length wrong");
  a_wide_when_init_low: assert property (
    !init_enable && !hitless_recovery |-> !loop_res_high)
    else $error("init low but narrow");
  a_no_hs_option: assert property (
    !hs_on |=> !hitless_recovery)
    else $error("recovery ran while absent");
  a_single_reselect: assert property (
    auto_spent && auto_mode |=> $stable(switched))
    else $error("second auto reselection");
  c_recovery_done: cover property (
    state == hitless_pkg::ST_RESUME ##1 state == hitless_pkg::ST_ARMED);
  c_auto_switch: cover property (auto_armed && lol_rise && auto_mode);
  c_init_narrow: cover property (!init_done ##1 init_done);

endmodule // hitless_switch_bandwidth_ctrl
`default_nettype wire

// >>> verification/pd_partner_model.sv
// Model of the phase detector and reference side that feeds the control block
`timescale 1ns/1ps
`default_nettype none

module pd_partner_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Stimulus control
  input  wire logic [1:0] err_mode,  // 0 good, 1 transient, 2 marginal
  input  wire logic [1:0] good_err,  // Error used while good
  input  wire logic       slow,      // One detector cycle in three
  // Detector outputs
  output logic            pd_valid,
  output logic [3:0]      phase_err_ns
);
  // ---------------------------------------------------------------
  // Detector cycle generation
  // ---------------------------------------------------------------
  logic [1:0] gap;  // Spacing counter for slow mode

  // Pulse per detector cycle; error is scrambled between cycles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap          <= 2'h0;
      pd_valid     <= 1'h0;
      phase_err_ns <= 4'h0;
    end else begin
      gap      <= (gap == 2'h2) ? 2'h0 : gap + 2'h1;
      pd_valid <= !slow || gap == 2'h0;
      if (!slow || gap == 2'h0) begin
        // Transient of five ns, marginal of three, good at good_err (zero to three)
        phase_err_ns <= (err_mode == 2'h1) ? 4'h5 :
                        (err_mode == 2'h2) ? 4'h3 : {2'h0, good_err};
      end else begin
        // Error is not held outside a valid cycle
        phase_err_ns <= ~phase_err_ns;
      end
    end
  end
endmodule // pd_partner_model

`default_nettype wire

// >>> verification/hitless_switch_bandwidth_ctrl_tb.sv
// Self-checking bench for the hitless recovery and bandwidth control block
`timescale 1ns/1ps
`default_nettype none
`include "hitless_regs.svh"

module hitless_switch_bandwidth_ctrl_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic        auto_mode, ref_select, narrow_loop_select, init_enable;
  logic        pd_valid, lock_loss_flag, ref_ack, pd_enable, loop_res_high;
  logic        fb_edge_load, hitless_recovery, irq, slow;
  logic [3:0]  phase_err_ns, nearest_edge, fb_edge_sel;
  logic [1:0]  err_mode, good_err;
  logic [31:0] exp_q[$];  // Expected read data in issue order
  int          err_total, tests_run, n;

  // Design and far side
  hitless_switch_bandwidth_ctrl uut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .auto_mode, .ref_select, .narrow_loop_select,
    .init_enable, .pd_valid, .phase_err_ns, .nearest_edge, .lock_loss_flag, .ref_ack,
    .pd_enable, .loop_res_high, .fb_edge_sel, .fb_edge_load, .hitless_recovery, .irq);
  pd_partner_model far_side (.clk, .sys_rst, .err_mode, .good_err, .slow, .pd_valid,
    .phase_err_ns);

  // Clock of 25 ns
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; reads leave their expectation in the queue
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    @(posedge clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    if (!w) exp_q.push_back(exp);
    @(posedge clk);
    penable <= 1'h1;
    // Hold the access phase until the slave answers; the watchdog bounds it
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    check("pslverr", pslverr, err);
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // Bounded wait for an output level
  task automatic wait_sig(input int which, input logic v);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      if ((which == 0 ? lock_loss_flag : which == 1 ? hitless_recovery :
           which == 2 ? fb_edge_load : ref_ack) === v) return;
    end
    check("wait_level", 32'h0, 32'h1);
  endtask

  // One transient detector cycle with a fresh random edge index
  task automatic transient;
    @(posedge clk);
    seed = xs(seed);
    err_mode     <= 2'h1;
    nearest_edge <= seed[3:0];
    good_err     <= 2'(seed[9:8] % 2'h3);
    // Hold until the model has shown the transient on a valid cycle
    do begin
      @(posedge clk);
    end while (pd_valid !== 1'h1 || phase_err_ns !== 4'h5);
    err_mode     <= 2'h0;
  endtask

  // Full recovery run with the expected reference indicator
  task automatic recover(input logic ack);
    transient;
    wait_sig(1, 1'h1);
    check("pd_enable_off", pd_enable, 1'h0);
    check("narrow_forced", loop_res_high, 1'h1);
    wait_sig(2, 1'h1);
    check("ref_ack", ref_ack, ack);
    check("fb_edge_sel", fb_edge_sel, nearest_edge);
    check("pd_enable_on", pd_enable, 1'h1);
    wait_sig(0, 1'h0);
    for (n = 0; n < 300 && hitless_recovery !== 1'h0; n++) @(posedge clk);
    check("resume_span", n >= `RESUME_CYC - 1 && n <= `RESUME_CYC + 2, 1'h1);
    check("wide_back", loop_res_high, 1'h0);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Read monitor: oldest expectation against each completed read
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1 && pwrite === 1'h0) begin
      if (exp_q.size() > 0) check("prdata", prdata, exp_q.pop_front());
    end
  end

  // Watchdog
  initial begin
    #(25 * 20000);
    err_total++;
    report_and_stop;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {sys_rst, narrow_loop_select, init_enable} = 3'h7;
    {psel, penable, pwrite, auto_mode, ref_select, slow} = 6'h0;
    {paddr, pwdata, nearest_edge, good_err, err_mode} = {50'h0, 2'h1};
    {seed, err_total, tests_run} = {32'h20, 64'h0};
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    apb(1'h0, `OFS_CTRL, 32'h0, 32'h1, 1'h0);
    apb(1'h0, `OFS_IRQ_MASK, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 12'h010, 32'h0, 32'h0, 1'h1);
    apb(1'h1, 12'h014, 32'hFFFFFFFF, 32'h0, 1'h1);
    check("lol_unlocked", lock_loss_flag, 1'h1);
    check("init_wide", loop_res_high, 1'h0);
    // Lock, then narrow request takes effect
    @(posedge clk);
    err_mode <= 2'h0;
    wait_sig(0, 1'h0);
    repeat (2) @(posedge clk);
    check("init_narrow", loop_res_high, 1'h1);
    apb(1'h0, `OFS_STATE, 32'h0, 32'h51, 1'h0);
    init_enable <= 1'h0;
    repeat (2) @(posedge clk);
    check("init_low_wide", loop_res_high, 1'h0);
    init_enable        <= 1'h1;
    narrow_loop_select <= 1'h0;
    repeat (2) @(posedge clk);
    check("pin_wide", loop_res_high, 1'h0);
    // Manual mode recovery, then interrupt masking and clearing
    recover(1'h0);
    apb(1'h0, `OFS_IRQ_STATUS, 32'h0, 32'h3, 1'h0);
    check("irq_masked", irq, 1'h0);
    apb(1'h1, `OFS_IRQ_MASK, 32'h7, 32'h0, 1'h0);
    @(posedge clk);
    check("irq_on", irq, 1'h1);
    apb(1'h1, `OFS_IRQ_STATUS, 32'h3, 32'h0, 1'h0);
    apb(1'h0, `OFS_IRQ_STATUS, 32'h0, 32'h0, 1'h0);
    check("irq_off", irq, 1'h0);
    // Automatic mode: one switch per arming, re-armed by manual mode, slow detector
    slow      <= 1'h1;
    auto_mode <= 1'h1;
    repeat (3) @(posedge clk);
    recover(1'h1);
    apb(1'h0, `OFS_IRQ_STATUS, 32'h0, 32'h7, 1'h0);
    apb(1'h1, `OFS_IRQ_STATUS, 32'h7, 32'h0, 1'h0);
    recover(1'h1);
    ref_select <= 1'h1;
    auto_mode  <= 1'h0;
    repeat (3) @(posedge clk);
    check("ack_pair_one", ref_ack, 1'h1);
    auto_mode <= 1'h1;
    repeat (3) @(posedge clk);
    recover(1'h0);
    // Recovery switched off in control
    apb(1'h1, `OFS_CTRL, 32'h0, 32'h0, 1'h0);
    transient;
    repeat (20) @(posedge clk);
    check("no_recovery", hitless_recovery, 1'h0);
    wait_sig(0, 1'h0);
    report_and_stop;
  end
endmodule // hitless_switch_bandwidth_ctrl_tb

`default_nettype wire
